/* File: shared/ccmpn_pkg.sv */
package ccmpn_pkg;
  localparam int PN_W = 48;
  localparam int SN_W_STD = 8;
  localparam int SN_W_EXT = 9;
  localparam int SN_W_MAX = 9;
  localparam int NONCE_PN_FIRST = 2;
  localparam int NONCE_PN_BYTES = 6;
  localparam logic [PN_W-1:0] PN_RST = 48'h0;
  localparam logic [7:0] ERR_NO_KEY = 8'h01;
  localparam logic [7:0] ERR_NONE = 8'h00;

  typedef enum logic [1:0] {
    CCMPN_IDLE,
    CCMPN_OPEN
  } ccmpn_state_t;

  // one sequence-number event from the link layer
  typedef struct packed {
    logic valid;
    logic first_seg;
    logic [SN_W_MAX-1:0] seq;
  } ccmpn_sn_t;

  // packet number laid out as nonce bytes 2..7, msb first
  typedef struct packed {
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
    logic [7:0] b7;
  } ccmpn_nonce_pn_t;
endpackage

/* File: verilog/ccmpn_counter.sv */
`timescale 1ns/1ps
// How it works
// - packet number is 48 bits, low part equals the link sequence number
// - transmit low bits copy sequence number of pdu carrying first segment
// - explicit part is 8 bits, or 9 in extended frame format
// - upper implicit counter increments each time sequence number wraps
// - receive low bits come from first pdu sequence number of the sdu
// - receive upper bits follow previous number, bumped on low-bit overflow
// - encrypted-only from link start; clear frames never allowed
// - call setup refused with error code when no derived key exists
// - packet number goes to nonce bytes 2 to 7, msb first
module ccmpn_counter import ccmpn_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic extended_seq_frame_format,
  input wire logic virtual_call_setup_req,
  input wire logic virtual_call_release,
  input wire logic derived_key_valid,
  input wire ccmpn_sn_t tx_sn,
  input wire ccmpn_sn_t rx_sn,
  input wire logic tx_frame_req,
  output logic link_open,
  output logic setup_ack,
  output logic setup_err,
  output logic [7:0] setup_err_code,
  output logic [PN_W-1:0] tx_pn,
  output logic tx_pn_valid,
  output ccmpn_nonce_pn_t tx_nonce_pn,
  output logic [PN_W-1:0] rx_pn,
  output logic rx_pn_valid,
  output ccmpn_nonce_pn_t rx_nonce_pn,
  output logic tx_frame_grant
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [SN_W_MAX-1:0] sn_mask(input logic ext);
    sn_mask = ext ? 9'h1ff : 9'h0ff;
  endfunction

  // splice explicit bits under an implicit counter of the matching width
  function automatic logic [PN_W-1:0] pn_join(input logic ext, input logic [PN_W-1:0] hi,
                                               input logic [SN_W_MAX-1:0] sn);
    pn_join = ext ? {hi[PN_W-SN_W_EXT-1:0], sn[SN_W_EXT-1:0]}
                  : {hi[PN_W-SN_W_STD-1:0], sn[SN_W_STD-1:0]};
  endfunction

  function automatic ccmpn_nonce_pn_t to_nonce(input logic [PN_W-1:0] pn);
    to_nonce = ccmpn_nonce_pn_t'(pn);
  endfunction

  // ------------------------------------------------------------
  // link state
  // ------------------------------------------------------------
  ccmpn_state_t state_q, state_d;
  logic ext_q, ext_d;
  logic setup_ack_q, setup_ack_d;
  logic setup_err_q, setup_err_d;
  logic [7:0] err_code_q, err_code_d;
  logic create;

  always_comb begin
    state_d = state_q;
    ext_d = ext_q;
    setup_ack_d = 1'b0;
    setup_err_d = 1'b0;
    err_code_d = err_code_q;
    create = 1'b0;
    case (state_q)
      CCMPN_IDLE: begin
        if (virtual_call_setup_req) begin
          if (derived_key_valid) begin
            state_d = CCMPN_OPEN;
            setup_ack_d = 1'b1;
            err_code_d = ERR_NONE;
            ext_d = extended_seq_frame_format;
            create = 1'b1;
          end else begin
            setup_err_d = 1'b1;
            err_code_d = ERR_NO_KEY;
          end
        end
      end
      CCMPN_OPEN: begin
        if (virtual_call_release) begin
          state_d = CCMPN_IDLE;
        end
      end
      default: begin
        state_d = CCMPN_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= CCMPN_IDLE;
      ext_q <= 1'b0;
      setup_ack_q <= 1'b0;
      setup_err_q <= 1'b0;
      err_code_q <= ERR_NONE;
    end else if (clk_en) begin
      state_q <= state_d;
      ext_q <= ext_d;
      setup_ack_q <= setup_ack_d;
      setup_err_q <= setup_err_d;
      err_code_q <= err_code_d;
    end
  end

  assign link_open = (state_q == CCMPN_OPEN);
  assign setup_ack = setup_ack_q;
  assign setup_err = setup_err_q;
  assign setup_err_code = err_code_q;
  assign tx_frame_grant = tx_frame_req && link_open;

  // ------------------------------------------------------------
  // packet number tracking, one copy per direction
  // ------------------------------------------------------------
  logic [PN_W-1:0] tx_hi_q, tx_hi_d, rx_hi_q, rx_hi_d;
  logic [SN_W_MAX-1:0] tx_last_q, tx_last_d, rx_last_q, rx_last_d;
  logic tx_seen_q, tx_seen_d, rx_seen_q, rx_seen_d;
  logic [PN_W-1:0] tx_pn_q, tx_pn_d, rx_pn_q, rx_pn_d;
  logic tx_v_q, tx_v_d, rx_v_q, rx_v_d;
  logic [SN_W_MAX-1:0] tx_seq, rx_seq;
  logic tx_wrap, rx_wrap;
  logic [PN_W-1:0] tx_hi_n, rx_hi_n;

  always_comb begin
    tx_seq = tx_sn.seq & sn_mask(ext_q);
    rx_seq = rx_sn.seq & sn_mask(ext_q);
    tx_wrap = tx_seen_q && (tx_seq < tx_last_q);
    rx_wrap = rx_seen_q && (rx_seq < rx_last_q);
    tx_hi_n = tx_wrap ? tx_hi_q + 48'h1 : tx_hi_q;
    rx_hi_n = rx_wrap ? rx_hi_q + 48'h1 : rx_hi_q;
    tx_hi_d = tx_hi_q;
    rx_hi_d = rx_hi_q;
    tx_last_d = tx_last_q;
    rx_last_d = rx_last_q;
    tx_seen_d = tx_seen_q;
    rx_seen_d = rx_seen_q;
    tx_pn_d = tx_pn_q;
    rx_pn_d = rx_pn_q;
    tx_v_d = 1'b0;
    rx_v_d = 1'b0;
    if (create) begin
      tx_hi_d = PN_RST;
      rx_hi_d = PN_RST;
      tx_seen_d = 1'b0;
      rx_seen_d = 1'b0;
    end else if (link_open) begin
      if (tx_sn.valid) begin
        tx_hi_d = tx_hi_n;
        tx_last_d = tx_seq;
        tx_seen_d = 1'b1;
        if (tx_sn.first_seg) begin
          tx_pn_d = pn_join(ext_q, tx_hi_n, tx_seq);
          tx_v_d = 1'b1;
        end
      end
      if (rx_sn.valid) begin
        rx_hi_d = rx_hi_n;
        rx_last_d = rx_seq;
        rx_seen_d = 1'b1;
        if (rx_sn.first_seg) begin
          rx_pn_d = pn_join(ext_q, rx_hi_n, rx_seq);
          rx_v_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_hi_q <= PN_RST;
      rx_hi_q <= PN_RST;
      tx_last_q <= '0;
      rx_last_q <= '0;
      tx_seen_q <= 1'b0;
      rx_seen_q <= 1'b0;
      tx_pn_q <= PN_RST;
      rx_pn_q <= PN_RST;
      tx_v_q <= 1'b0;
      rx_v_q <= 1'b0;
    end else if (clk_en) begin
      tx_hi_q <= tx_hi_d;
      rx_hi_q <= rx_hi_d;
      tx_last_q <= tx_last_d;
      rx_last_q <= rx_last_d;
      tx_seen_q <= tx_seen_d;
      rx_seen_q <= rx_seen_d;
      tx_pn_q <= tx_pn_d;
      rx_pn_q <= rx_pn_d;
      tx_v_q <= tx_v_d;
      rx_v_q <= rx_v_d;
    end
  end

  assign tx_pn = tx_pn_q;
  assign rx_pn = rx_pn_q;
  assign tx_pn_valid = tx_v_q;
  assign rx_pn_valid = rx_v_q;
  assign tx_nonce_pn = to_nonce(tx_pn_q);
  assign rx_nonce_pn = to_nonce(rx_pn_q);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_grant_needs_link;
    @(posedge sys_clk) disable iff (sys_rst) tx_frame_grant |-> link_open;
  endproperty
  a_grant_needs_link: assert property (p_grant_needs_link) else $error("clear frame granted");

  // link may only open through a keyed, acknowledged setup
  property p_open_needs_ack;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(link_open) |-> (setup_ack && setup_err_code == ERR_NONE);
  endproperty
  a_open_needs_ack: assert property (p_open_needs_ack) else $error("link opened unkeyed");

  property p_no_key_refused;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && state_q == CCMPN_IDLE && virtual_call_setup_req && !derived_key_valid)
      |=> (setup_err && setup_err_code == ERR_NO_KEY && !link_open);
  endproperty
  a_no_key_refused: assert property (p_no_key_refused) else $error("setup without key");

  property p_tx_low_bits;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && link_open && !create && tx_sn.valid && tx_sn.first_seg && !ext_q)
      |=> tx_pn_valid && tx_pn[SN_W_STD-1:0] == $past(tx_sn.seq[SN_W_STD-1:0]);
  endproperty
  a_tx_low_bits: assert property (p_tx_low_bits) else $error("tx low bits wrong");

  property p_rx_low_bits;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && link_open && !create && rx_sn.valid && rx_sn.first_seg && ext_q)
      |=> rx_pn_valid && rx_pn[SN_W_EXT-1:0] == $past(rx_sn.seq[SN_W_EXT-1:0]);
  endproperty
  a_rx_low_bits: assert property (p_rx_low_bits) else $error("rx low bits wrong");

  property p_tx_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && link_open && !create && tx_sn.valid && tx_wrap) |=> tx_hi_q == $past(tx_hi_q) + 48'h1;
  endproperty
  a_tx_wrap: assert property (p_tx_wrap) else $error("tx wrap missed");

  property p_rx_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && link_open && !create && rx_sn.valid && rx_wrap) |=> rx_hi_q == $past(rx_hi_q) + 48'h1;
  endproperty
  a_rx_wrap: assert property (p_rx_wrap) else $error("rx wrap missed");

  property p_create_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && create) |=> (tx_hi_q == PN_RST && rx_hi_q == PN_RST && link_open);
  endproperty
  a_create_clear: assert property (p_create_clear) else $error("counter not cleared");

  property p_nonce_order;
    @(posedge sys_clk) disable iff (sys_rst) tx_nonce_pn.b2 == tx_pn[47:40] && tx_nonce_pn.b7 == tx_pn[7:0];
  endproperty
  a_nonce_order: assert property (p_nonce_order) else $error("nonce byte order");

  property p_ext_width;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && link_open && !create && tx_sn.valid && tx_sn.first_seg && ext_q)
      |=> tx_pn[SN_W_EXT-1:0] == $past(tx_sn.seq[SN_W_EXT-1:0]);
  endproperty
  a_ext_width: assert property (p_ext_width) else $error("extended width wrong");

endmodule // ccmpn_counter

/* File: tb/ccmpn_peer.sv */
`timescale 1ns/1ps
// ----
// far-end link layer
// ----
module ccmpn_peer import ccmpn_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ext,
  input wire logic clr,
  input wire logic go,
  input wire logic first,
  input wire logic [8:0] step,
  output ccmpn_sn_t rx_sn,
  output logic [PN_W-1:0] pn
);
  logic [8:0] mask;
  logic [8:0] nxt;
  logic [8:0] seq_q;
  logic [PN_W-1:0] hi_q;
  assign mask = ext ? 9'h1ff : 9'h0ff;
  assign nxt = (seq_q + step) & mask;
  assign pn = (hi_q << (ext ? 9 : 8)) | PN_W'(seq_q);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_q <= '0;
      seq_q <= '0;
      rx_sn <= '0;
    end else begin
      if (clr) begin
        hi_q <= '0;
        seq_q <= '0;
      end else if (go) begin
        if (nxt < seq_q) hi_q <= hi_q + 48'h1;
        seq_q <= nxt;
        rx_sn <= {1'b1, first, nxt};
      end
      // released line flips its seq every cycle, alternating inverse and last value
      if (clr || !go) rx_sn <= {1'b0, 1'b0, ~rx_sn.seq};
    end
  end
endmodule // ccmpn_peer

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ccmpn_pkg::*;
  logic sys_clk = 0, sys_rst = 1, clk_en = 1, ext = 0, req = 0, rel = 0, key = 0;
  logic tfr = 1, go = 0, first = 0;
  logic [8:0] step = '0;
  logic [8:0] tseq;
  ccmpn_sn_t tx_sn = '0, rx_sn;
  logic link_open, setup_ack, setup_err, tx_pn_valid, rx_pn_valid, tx_frame_grant;
  logic [7:0] setup_err_code;
  logic [PN_W-1:0] tx_pn, rx_pn, peer_pn;
  ccmpn_nonce_pn_t tx_nonce_pn, rx_nonce_pn;
  int err_total = 0, n_checks = 0, cyc = 0, thi;
  ccmpn_counter dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .extended_seq_frame_format(ext), .virtual_call_setup_req(req),
    .virtual_call_release(rel), .derived_key_valid(key), .tx_sn(tx_sn), .rx_sn(rx_sn),
    .tx_frame_req(tfr), .link_open(link_open), .setup_ack(setup_ack),
    .setup_err(setup_err), .setup_err_code(setup_err_code), .tx_pn(tx_pn),
    .tx_pn_valid(tx_pn_valid), .tx_nonce_pn(tx_nonce_pn), .rx_pn(rx_pn),
    .rx_pn_valid(rx_pn_valid), .rx_nonce_pn(rx_nonce_pn), .tx_frame_grant(tx_frame_grant));
  ccmpn_peer peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .ext(ext), .clr(req), .go(go),
    .first(first), .step(step), .rx_sn(rx_sn), .pn(peer_pn));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task summarize;
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task setup(input logic k, input logic x);
    @(posedge sys_clk);
    req <= 1'b1;
    key <= k;
    ext <= x;
    tfr <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    #1;
    chk(48'(setup_ack), 48'(k));
    chk(48'(setup_err), 48'(!k));
    chk(48'(setup_err_code), 48'(k ? ERR_NONE : ERR_NO_KEY));
    chk(48'(tx_frame_grant), 48'(k));
    thi = 0;
    tseq = '0;
  endtask
  // ----
  // one pdu each way, tx pn checked against integer model, rx pn against peer pn
  // ----
  task step_pair;
    logic [8:0] m, s, st;
    logic f;
    logic [PN_W-1:0] e;
    m = ext ? 9'h1ff : 9'h0ff;
    st = 9'($urandom_range(int'(m), 1));
    s = (tseq + st) & m;
    if (s < tseq) thi++;
    tseq = s;
    e = (PN_W'(thi) << (ext ? 9 : 8)) | PN_W'(s);
    f = 1'($urandom % 2);
    @(posedge sys_clk);
    // stray upper bit must be masked off
    tx_sn <= {1'b1, f, s | ~m};
    tfr <= 1'($urandom % 2);
    step <= st;
    first <= f;
    go <= 1'b1;
    @(posedge sys_clk);
    tx_sn <= {1'b0, 1'b0, ~s};
    go <= 1'b0;
    #1;
    chk(48'(tx_frame_grant), 48'(tfr));
    chk(48'(tx_pn_valid), 48'(f));
    if (f) chk(tx_pn, e);
    if (f) chk(tx_nonce_pn, e);
    @(posedge sys_clk);
    #1;
    chk(48'(rx_pn_valid), 48'(f));
    if (f) chk(rx_pn, peer_pn);
    if (f) chk(rx_nonce_pn, peer_pn);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1500) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    void'($urandom(74821));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk(48'(tx_frame_grant), 48'h0);
    chk(tx_pn, PN_RST);
    setup(1'b0, 1'b0);
    chk(48'(link_open), 48'h0);
    // gated clock must not take a request
    @(posedge sys_clk);
    clk_en <= 1'b0;
    req <= 1'b1;
    key <= 1'b1;
    repeat (2) @(posedge sys_clk);
    req <= 1'b0;
    clk_en <= 1'b1;
    #1;
    chk(48'(link_open), 48'h0);
    for (int r = 0; r < 2; r++) begin
      setup(1'b1, 1'(r));
      repeat (60) step_pair();
      @(posedge sys_clk);
      rel <= 1'b1;
      @(posedge sys_clk);
      rel <= 1'b0;
      #1;
      chk(48'(tx_frame_grant), 48'h0);
    end
    summarize();
  end
endmodule // tb_top
